// *** design/primary_status.v ***
// primary status register: live indicator gathering and host read port
`include "status_map.vh"
module primary_status
#(
   // width of each interrupt pending and enable group
   parameter IRQ_W = 8
)
(
   // clock and reset
   input wire CLOCK,
   input wire RST_N,
   // host register port
   input wire [5:0] ADDR,
   input wire RD_EN,
   input wire WR_EN,
   input wire [7:0] WR_DATA,
   output reg [7:0] RD_DATA,
   // carrier frequency detector result (frequency judged in MHz)
   input wire [7:0] CARRIER_MHZ,
   // crc coprocessor
   input wire CRC_BUSY,
   input wire CRC_RESULT_ZERO,
   input wire CRC_FINISHED,
   input wire CRC_START,
   // interrupts
   input wire [IRQ_W-1:0] COMM_IRQ_PENDING,
   input wire [IRQ_W-1:0] COMM_IRQ_ENABLES,
   input wire [IRQ_W-1:0] MISC_IRQ_PENDING,
   input wire [IRQ_W-1:0] MISC_IRQ_ENABLES,
   // timer
   input wire TIMER_ENABLE,
   input wire TIMER_COUNTING,
   input wire TIMER_GATED_MODE,
   // field detector
   input wire FIELD_DETECT,
   // fifo level
   input wire [6:0] FIFO_BYTE_COUNT,
   input wire [5:0] FIFO_WATERMARK,
   // live status copy
   output reg [7:0] STATUS
);

   // -----------------------------
   // internal state
   // -----------------------------
   reg crc_done_r;
   reg crc_done_nxt;
   reg freq_ok_nxt;
   reg crc_ok_nxt;
   reg irq_nxt;
   reg timer_nxt;
   reg field_nxt;
   reg high_nxt;
   reg low_nxt;
   reg [7:0] status_nxt;
   reg [7:0] rd_data_nxt;
   wire [6:0] fifo_free;
   wire [6:0] mark_ext;
   wire [IRQ_W-1:0] comm_hit;
   wire [IRQ_W-1:0] misc_hit;
   wire read_hit;
   genvar i;

   // -----------------------------
   // level compare used by both fifo alerts
   // -----------------------------
   function at_or_below;
      input [6:0] level;
      input [6:0] mark;
      begin
         at_or_below = (level <= mark);
      end
   endfunction

   // -----------------------------
   // crc done flag
   // -----------------------------
   always @*
   begin
      if (CRC_FINISHED)
         crc_done_nxt = 1'b1;
      else if (CRC_START)
         crc_done_nxt = 1'b0;
      else
         crc_done_nxt = crc_done_r;
   end

   always @(posedge CLOCK)
   begin
      if (!RST_N)
         crc_done_r <= 1'b0;
      else
         crc_done_r <= crc_done_nxt;
   end

   // -----------------------------
   // carrier frequency window
   // -----------------------------
   always @*
   begin
      // in-range test is strict; outer bands left to detector
      if ((CARRIER_MHZ > `FREQ_LO_MHZ) && (CARRIER_MHZ < `FREQ_HI_MHZ))
         freq_ok_nxt = 1'b1;
      else
         freq_ok_nxt = 1'b0;
   end

   // -----------------------------
   // crc coprocessor result
   // -----------------------------
   always @*
   begin
      // crc ok only reflects the coprocessor; frame errors elsewhere
      if (CRC_BUSY)
         crc_ok_nxt = 1'b0;
      else
         crc_ok_nxt = CRC_RESULT_ZERO;
   end

   // -----------------------------
   // interrupt request
   // -----------------------------
   generate
      for (i = 0; i < IRQ_W; i = i + 1)
      begin : irq_mask
         assign comm_hit[i] = COMM_IRQ_PENDING[i] & COMM_IRQ_ENABLES[i];
         assign misc_hit[i] = MISC_IRQ_PENDING[i] & MISC_IRQ_ENABLES[i];
      end
   endgenerate

   always @*
   begin
      irq_nxt = (|comm_hit) || (|misc_hit);
   end

   // -----------------------------
   // timer running
   // -----------------------------
   always @*
   begin
      if (TIMER_GATED_MODE)
         timer_nxt = TIMER_ENABLE;
      else
         timer_nxt = TIMER_ENABLE && TIMER_COUNTING;
   end

   // -----------------------------
   // field presence
   // -----------------------------
   always @*
   begin
      field_nxt = FIELD_DETECT;
   end

   // -----------------------------
   // fifo alerts
   // -----------------------------
   assign mark_ext = {1'b0, FIFO_WATERMARK};
   assign fifo_free = `FIFO_DEPTH - FIFO_BYTE_COUNT;

   always @*
   begin
      high_nxt = at_or_below(fifo_free, mark_ext);
      low_nxt = at_or_below(FIFO_BYTE_COUNT, mark_ext);
   end

   // -----------------------------
   // indicator assembly
   // -----------------------------
   always @*
   begin
      status_nxt = `STATUS_ZERO;
      status_nxt[`BIT_FREQ] = freq_ok_nxt;
      status_nxt[`BIT_CRC_OK] = crc_ok_nxt;
      status_nxt[`BIT_CRC_DONE] = crc_done_nxt;
      status_nxt[`BIT_IRQ] = irq_nxt;
      status_nxt[`BIT_TIMER] = timer_nxt;
      status_nxt[`BIT_FIELD] = field_nxt;
      status_nxt[`BIT_HIGH] = high_nxt;
      status_nxt[`BIT_LOW] = low_nxt;
   end

   // -----------------------------
   // write port
   // -----------------------------
   // writes land nowhere; the register is read-only

   // -----------------------------
   // read decode
   // -----------------------------
   assign read_hit = RD_EN && (ADDR == `PRIMARY_STATUS_ADDR);

   always @*
   begin
      if (read_hit)
         rd_data_nxt = status_nxt;
      else
         rd_data_nxt = `STATUS_ZERO;
   end

   // -----------------------------
   // registered status
   // -----------------------------
   always @(posedge CLOCK)
   begin
      if (!RST_N)
         STATUS <= `STATUS_RESET;
      else
         STATUS <= status_nxt;
   end

   // -----------------------------
   // registered read data
   // -----------------------------
   always @(posedge CLOCK)
   begin
      if (!RST_N)
         RD_DATA <= `STATUS_ZERO;
      else
         RD_DATA <= rd_data_nxt;
   end

endmodule // primary_status

// *** design/status_map.vh ***
// constants for the primary status register block
// Notes on behaviour
// - freq ok when 12 < f < 15 MHz
// - 9-12 and 15-19 MHz bands unchecked
// - crc ok low while busy, high zero
// - crc ok undefined during frames; error flag
// - crc done set when standalone crc finishes
// - irq high when enabled source pending
// - timer running while counter will decrement
// - gated mode follows enable, ignores gate
// - field present follows detector, no latch
// - high alert when 64-count <= watermark
// - low alert when count <= watermark
// - register at 07h, bit layout, reset X100X01X
`ifndef STATUS_MAP_VH
`define STATUS_MAP_VH
`define PRIMARY_STATUS_ADDR 6'h07
`define FIFO_DEPTH 7'h40
`define FREQ_LO_MHZ 8'h0C
`define FREQ_HI_MHZ 8'h0F
`define BIT_FREQ 7
`define BIT_CRC_OK 6
`define BIT_CRC_DONE 5
`define BIT_IRQ 4
`define BIT_TIMER 3
`define BIT_FIELD 2
`define BIT_HIGH 1
`define BIT_LOW 0
`define STATUS_RESET 8'h42
`define STATUS_ZERO 8'h00
`endif

// *** tb/host_model.sv ***
// host side issuing status reads
module host_model(input wire CLOCK, input wire [7:0] RD_DATA, output logic RD_EN = 0,
   output logic [5:0] ADDR = 0);
   timeunit 1ns;
   timeprecision 1ns;
   task rd(input logic [5:0] a, output logic [7:0] v);
      @(negedge CLOCK);
      {RD_EN, ADDR} = {1'b1, a};
      @(negedge CLOCK);
      v = RD_DATA;
      RD_EN = 0;
   endtask
endmodule // host_model

// *** tb/status_chk_asserts.sv ***
// assertions on the primary status ports
module status_chk(input wire CLOCK, RST_N, RD_EN, FIELD_DETECT, CRC_BUSY, TIMER_ENABLE,
   TIMER_GATED_MODE, input wire [5:0] ADDR, input wire [7:0] RD_DATA, STATUS);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   chk_fld_live: assert property (##1 STATUS[2] == $past(FIELD_DETECT))
      else $error("fld");
   chk_fld_drop: assert property ($fell(FIELD_DETECT) |=> !STATUS[2])
      else $error("drop");
   chk_crc_busy: assert property (CRC_BUSY |=> !STATUS[6]) else $error("crc");
   chk_gate_en: assert property (TIMER_GATED_MODE |=> STATUS[3] == $past(TIMER_ENABLE))
      else $error("gate");
   chk_tmr_off: assert property (!TIMER_ENABLE |=> !STATUS[3]) else $error("tmr");
   chk_rd_hit: assert property (RD_EN && ADDR == 6'h07 |=> RD_DATA == STATUS)
      else $error("hit");
   chk_rd_miss: assert property (RD_EN && ADDR != 6'h07 |=> RD_DATA == 8'h00)
      else $error("mis");
   chk_rd_idle: assert property (!RD_EN |=> RD_DATA == 8'h00) else $error("idle");
endmodule // status_chk
bind primary_status status_chk u_chk(.*);

// *** tb/test_primary_status.sv ***
// bench for the primary status register
module test_primary_status;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK = 0, RST_N = 0, WR_EN = 0, CRC_BUSY = 0, CRC_RESULT_ZERO = 0, CRC_FINISHED = 0;
   logic CRC_START = 0, TIMER_ENABLE = 0, TIMER_COUNTING = 0, TIMER_GATED_MODE = 0;
   logic FIELD_DETECT = 0, RD_EN;
   logic [5:0] ADDR, FIFO_WATERMARK = 0;
   logic [6:0] FIFO_BYTE_COUNT = 0;
   logic [7:0] WR_DATA = 0, CARRIER_MHZ = 0, RD_DATA, STATUS, d, COMM_IRQ_ENABLES = 0;
   logic [7:0] MISC_IRQ_PENDING = 0, MISC_IRQ_ENABLES = 0, COMM_IRQ_PENDING = 1;
   int bad_count = 0, cmp_count = 0;
   primary_status dut(.*);
   host_model hst(.*);
   always #5 CLOCK = ~CLOCK;
   task chk(input logic [7:0] g, e);
      cmp_count++;
      bad_count += (g !== e);
      if (g !== e)
         $display("[ERR] %0t got %h exp %h", $time, g, e);
   endtask
   task step(input logic [28:0] v, input logic [7:0] e);
      @(negedge CLOCK);
      {CARRIER_MHZ, FIFO_BYTE_COUNT, FIFO_WATERMARK, FIELD_DETECT, CRC_BUSY, CRC_RESULT_ZERO,
         TIMER_GATED_MODE, TIMER_ENABLE, TIMER_COUNTING, COMM_IRQ_ENABLES[0], WR_EN} = v;
      hst.rd(6'h07, d);
      chk(d, e);
   endtask
   task wrap_up;
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #2000;
      bad_count++;
      wrap_up;
   end
   initial
   begin
      repeat (5) @(negedge CLOCK);
      chk(STATUS, 8'h42);
      RST_N = 1;
      CRC_FINISHED = 1;
      @(negedge CLOCK);
      CRC_FINISHED = 0;
      step({8'h0d, 7'h3c, 6'h04, 8'hba}, 8'hfe);
      step({8'h0d, 7'h3c, 6'h04, 8'hbb}, 8'hfe);
      CRC_START = 1;
      step({8'h14, 7'h3b, 6'h04, 8'h68}, 8'h00);
      step({8'h0d, 7'h04, 6'h04, 8'h0c}, 8'h89);
      {MISC_IRQ_PENDING, MISC_IRQ_ENABLES} = {8'h80, 8'h80};
      step({8'h0e, 7'h40, 6'h00, 8'h0c}, 8'h9a);
      step({8'h08, 7'h00, 6'h00, 8'h80}, 8'h15);
      hst.rd(6'h08, d);
      chk(d, 8'h00);
      wrap_up;
   end
endmodule // test_primary_status
